// *** logic/external_line_controller.sv ***
// Purpose: Edge-triggered interrupt and event controller, 21 lines
// Assumes: Bus inputs synchronous to clk_sys_in, single clock
// Notes: Lines 0-15 from pins, 16-20 from internal sources
//
// The implementer's own choice: the strobed register port.
module external_line_controller
  import line_ctrl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [`LC_PIN_LINES-1:0] pin_lines_in,
  input wire logic supply_voltage_detector_in,
  input wire logic calendar_alarm_in,
  input wire logic calendar_tamper_stamp_in,
  input wire logic calendar_wakeup_in,
  input wire logic basic_timer_wakeup_in,
  input wire logic [`LC_ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output line_vec_t line_irq_out,
  output line_vec_t event_pulse_out,
  output logic timestamp_trigger_out,
  output logic irq_out
);
  // ****************************************************************
  // Source lines and edge detection
  // ****************************************************************
  line_vec_t lines;
  edge_pair_s edges;
  reg_req_s req;
  logic [8:0] wsel;
  logic rd_hit;

  assign lines = {basic_timer_wakeup_in, calendar_wakeup_in,
    calendar_tamper_stamp_in, calendar_alarm_in,
    supply_voltage_detector_in, pin_lines_in};
  assign req = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in,
    wdata: reg_wdata_in};

  line_edge_detect u_edge
  (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .lines_in(lines),
    .edges_out(edges)
  );

  line_reg_port u_port
  (
    .req_in(req),
    .wsel_out(wsel),
    .rd_hit_out(rd_hit)
  );

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  line_vec_t event_mask_q;
  line_vec_t interrupt_mask_q;
  line_vec_t falling_edge_enable_q;
  line_vec_t rising_edge_enable_q;
  line_vec_t pending_flags_q;
  line_vec_t pending_flags_d;
  line_vec_t software_trigger_q;
  line_vec_t software_trigger_d;
  logic [`LC_TS_SEL_W-1:0] timestamp_source_field_q;
  line_vec_t wdata_lines;
  line_vec_t hw_trigger;
  line_vec_t sw_set;
  line_vec_t pending_flag_clear;
  line_vec_t polarity_change;

  // Reserved upper bits are not stored; software keeps them zero
  assign wdata_lines = reg_wdata_in[`LC_LINES-1:0];

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      event_mask_q <= '0;
      interrupt_mask_q <= '0;
      falling_edge_enable_q <= '0;
      rising_edge_enable_q <= '0;
    end
    else
    begin
      if (wsel[0])
        event_mask_q <= wdata_lines;
      if (wsel[1])
        interrupt_mask_q <= wdata_lines;
      if (wsel[2])
        falling_edge_enable_q <= wdata_lines;
      if (wsel[3])
        rising_edge_enable_q <= wdata_lines;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      timestamp_source_field_q <= '0;
    else if (wsel[6])
      timestamp_source_field_q <= reg_wdata_in[`LC_TS_SEL_W-1:0];
  end

  // ****************************************************************
  // Trigger, pending and software trigger
  // ****************************************************************
  assign hw_trigger = (edges.rise & rising_edge_enable_q)
    | (edges.fall & falling_edge_enable_q);
  // Only a 0-to-1 write of the trigger bit requests
  assign sw_set = wsel[5] ? (wdata_lines & ~software_trigger_q) : '0;
  assign pending_flag_clear = wsel[4] ? wdata_lines : '0;
  assign polarity_change = (wsel[2] ? (wdata_lines ^ falling_edge_enable_q)
    : '0) | (wsel[3] ? (wdata_lines ^ rising_edge_enable_q) : '0);

  genvar g;
  generate
    for (g = 0; g < `LC_LINES; g++)
    begin : g_line
      // New trigger wins over a clear in the same cycle
      always_comb
      begin
        pending_flags_d[g] = pending_flags_q[g];
        if (pending_flag_clear[g] | polarity_change[g])
          pending_flags_d[g] = 1'b0;
        if (hw_trigger[g] | sw_set[g])
          pending_flags_d[g] = 1'b1;
      end

      always_comb
      begin
        software_trigger_d[g] = software_trigger_q[g];
        if (wsel[5])
          software_trigger_d[g] = wdata_lines[g];
        if (pending_flag_clear[g])
          software_trigger_d[g] = 1'b0;
      end

      assign line_irq_out[g] = pending_flags_q[g] & interrupt_mask_q[g];
    end
  endgenerate

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pending_flags_q <= '0;
      software_trigger_q <= '0;
    end
    else
    begin
      pending_flags_q <= pending_flags_d;
      software_trigger_q <= software_trigger_d;
    end
  end

  // ****************************************************************
  // Event pulses and timestamp trigger
  // ****************************************************************
  line_vec_t event_pulse_q;
  logic timestamp_trigger_q;

  // Event path never touches pending; registered for a clean pulse
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      event_pulse_q <= '0;
      timestamp_trigger_q <= 1'b0;
    end
    else
    begin
      event_pulse_q <= (hw_trigger | sw_set) & event_mask_q;
      timestamp_trigger_q <= hw_trigger[timestamp_source_field_q];
    end
  end

  assign event_pulse_out = event_pulse_q;
  assign timestamp_trigger_out = timestamp_trigger_q;

  // ****************************************************************
  // Summary interrupt: sticky status, mask, one level output
  // ****************************************************************
  logic [`LC_SUM_W-1:0] sum_stat_q;
  logic [`LC_SUM_W-1:0] sum_mask_q;
  logic [`LC_SUM_W-1:0] sum_event;
  logic [`LC_SUM_W-1:0] sum_clear;

  assign sum_event[`LC_SUM_BIT_EDGE] = |(pending_flags_d & ~pending_flags_q
    & interrupt_mask_q);
  assign sum_event[`LC_SUM_BIT_TS] = timestamp_trigger_q;
  assign sum_clear = wsel[7] ? reg_wdata_in[`LC_SUM_W-1:0] : '0;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sum_stat_q <= '0;
      sum_mask_q <= '0;
    end
    else
    begin
      // Set wins over the write-one clear
      sum_stat_q <= (sum_stat_q & ~sum_clear) | sum_event;
      if (wsel[8])
        sum_mask_q <= reg_wdata_in[`LC_SUM_W-1:0];
    end
  end

  // Level ORs the masked sticky summary with the masked pending lines, so a missed summary clear holds it high
  assign irq_out = (|(sum_stat_q & sum_mask_q))
    | (|(pending_flags_q & interrupt_mask_q));

  // ****************************************************************
  // Read data, one cycle after the read strobe
  // ****************************************************************
  logic [31:0] rdata_d;

  always_comb
  begin
    rdata_d = `LC_RESET_WORD;
    case (reg_addr_in)
      `LC_OFF_EVENT_MASK: rdata_d[`LC_LINES-1:0] = event_mask_q;
      `LC_OFF_IRQ_MASK: rdata_d[`LC_LINES-1:0] = interrupt_mask_q;
      `LC_OFF_FALL_EN: rdata_d[`LC_LINES-1:0] = falling_edge_enable_q;
      `LC_OFF_RISE_EN: rdata_d[`LC_LINES-1:0] = rising_edge_enable_q;
      `LC_OFF_PENDING: rdata_d[`LC_LINES-1:0] = pending_flags_q;
      `LC_OFF_SW_TRIG: rdata_d[`LC_LINES-1:0] = software_trigger_q;
      `LC_OFF_TS_SEL: rdata_d[`LC_TS_SEL_W-1:0] = timestamp_source_field_q;
      `LC_OFF_SUM_STAT: rdata_d[`LC_SUM_W-1:0] = sum_stat_q;
      `LC_OFF_SUM_MASK: rdata_d[`LC_SUM_W-1:0] = sum_mask_q;
      default: rdata_d = `LC_RESET_WORD;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      reg_rdata_out <= `LC_RESET_WORD;
    else if (rd_hit)
      reg_rdata_out <= rdata_d;
    else
      reg_rdata_out <= `LC_RESET_WORD;
  end
endmodule // external_line_controller

// *** logic/line_ctrl_map.svh ***
// Purpose: Offsets, field positions, reset values for the line controller
// Assumes: 32-bit register port, word offsets are byte addresses
// Notes: Included by the package and the modules
// What this block does
// - Event unmask bit 0 blocks events per line
// - Interrupt unmask bit 0 blocks interrupts per line
// - Falling enable makes falling edges trigger
// - Rising enable makes rising edges trigger
// - Enabled edge sets line pending flag
// - Write one clears pending, zero keeps
// - Changing edge polarity clears pending flag
// - Software trigger write sets pending flag
// - Software request still gated by masks
// - Clearing pending also clears software trigger
// - Four-bit selector routes line to timestamp
// - All registers reset to zero
// - Enabled edge sets pending, raises interrupt if unmasked
// - Unmasked enabled edge emits event pulse
// - Lines 16 to 20 from internal sources
`ifndef LINE_CTRL_MAP_SVH
`define LINE_CTRL_MAP_SVH
`define LC_LINES 21
`define LC_PIN_LINES 16
`define LC_ADDR_W 8
`define LC_OFF_EVENT_MASK 8'h00
`define LC_OFF_IRQ_MASK 8'h04
`define LC_OFF_FALL_EN 8'h08
`define LC_OFF_RISE_EN 8'h0C
`define LC_OFF_PENDING 8'h10
`define LC_OFF_SW_TRIG 8'h14
`define LC_OFF_TS_SEL 8'h18
`define LC_OFF_SUM_STAT 8'h1C
`define LC_OFF_SUM_MASK 8'h20
`define LC_TS_SEL_W 4
`define LC_SUM_W 2
`define LC_SUM_BIT_EDGE 0
`define LC_SUM_BIT_TS 1
`define LC_RESET_WORD 32'h0000_0000
`endif

// *** logic/line_ctrl_pkg.sv ***
// Purpose: Types shared by the line controller modules
// Assumes: Map header defines the widths
// Notes: Only types live here
`include "line_ctrl_map.svh"
package line_ctrl_pkg;
  typedef logic [`LC_LINES-1:0] line_vec_t;
  typedef logic [`LC_ADDR_W-1:0] reg_addr_t;
  typedef struct packed
  {
    logic wr;
    logic rd;
    reg_addr_t addr;
    logic [31:0] wdata;
  } reg_req_s;
  typedef struct packed
  {
    line_vec_t rise;
    line_vec_t fall;
  } edge_pair_s;
endpackage

// *** logic/line_edge_detect.sv ***
// Purpose: Synchronise the source lines and flag their edges
// Assumes: Lines may be asynchronous to the clock
// Notes: One-cycle rise and fall pulses per line
module line_edge_detect
  import line_ctrl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire line_vec_t lines_in,
  output edge_pair_s edges_out
);
  line_vec_t sync1_q;
  line_vec_t sync2_q;
  line_vec_t last_q;

  // Last stage resets to zero, so a line high at release reads as a rise
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      last_q <= '0;
    end
    else
    begin
      sync1_q <= lines_in;
      sync2_q <= sync1_q;
      last_q <= sync2_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `LC_LINES; g++)
    begin : g_edge
      assign edges_out.rise[g] = sync2_q[g] & ~last_q[g];
      assign edges_out.fall[g] = ~sync2_q[g] & last_q[g];
    end
  endgenerate
endmodule // line_edge_detect

// *** logic/line_reg_port.sv ***
// Purpose: Decode the plain register port into strobes
// Assumes: One strobe at a time, never both
// Notes: Write strobes are one-hot per register
module line_reg_port
  import line_ctrl_pkg::*;
(
  input wire reg_req_s req_in,
  output logic [8:0] wsel_out,
  output logic rd_hit_out
);
  always_comb
  begin
    wsel_out = '0;
    rd_hit_out = 1'b0;
    case (req_in.addr)
      `LC_OFF_EVENT_MASK: wsel_out[0] = req_in.wr;
      `LC_OFF_IRQ_MASK: wsel_out[1] = req_in.wr;
      `LC_OFF_FALL_EN: wsel_out[2] = req_in.wr;
      `LC_OFF_RISE_EN: wsel_out[3] = req_in.wr;
      `LC_OFF_PENDING: wsel_out[4] = req_in.wr;
      `LC_OFF_SW_TRIG: wsel_out[5] = req_in.wr;
      `LC_OFF_TS_SEL: wsel_out[6] = req_in.wr;
      `LC_OFF_SUM_STAT: wsel_out[7] = req_in.wr;
      `LC_OFF_SUM_MASK: wsel_out[8] = req_in.wr;
      default: wsel_out = '0;
    endcase
    rd_hit_out = req_in.rd;
  end
endmodule // line_reg_port

// *** verif/line_ctrl_props.sv ***
// Purpose: Port properties of the line controller
// Assumes: Config is stable while edges are in flight
// Notes: Register shadows are rebuilt from bus writes
`include "line_ctrl_map.svh"
// ****
// Checker
// ****
module line_ctrl_props
  import line_ctrl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [`LC_PIN_LINES-1:0] pin_lines_in,
  input wire logic [`LC_ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire line_vec_t line_irq_out,
  input wire line_vec_t event_pulse_out,
  input wire logic timestamp_trigger_out,
  input wire logic irq_out
);
  default clocking dc @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);
  logic [31:0] sh_q [0:6];
  wire line_vec_t em = sh_q[0][20:0];
  wire line_vec_t im = sh_q[1][20:0];
  wire line_vec_t wlo = reg_wdata_in[20:0];
  wire logic sel_ln = pin_lines_in[sh_q[6][3:0]];
  wire logic sel_re = sh_q[3][sh_q[6][3:0]];
  // Summary block left out: it never gates lines
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      sh_q <= '{default: '0};
    else if (reg_wr_in && reg_addr_in < `LC_OFF_SUM_STAT)
      sh_q[reg_addr_in[4:2]] <= reg_wdata_in;
  end
  sequence s_clr;
    reg_wr_in && reg_addr_in == `LC_OFF_PENDING;
  endsequence
  sequence s_swt;
    reg_wr_in && reg_addr_in == `LC_OFF_SW_TRIG;
  endsequence
  a_event_gate: assert property ((event_pulse_out & ~$past(em)) == '0)
    else $error("event on masked line");
  a_irq_gate: assert property ((line_irq_out & ~im) == '0)
    else $error("irq on masked line");
  a_fall_irq:
    assert property ($fell(pin_lines_in[0]) && sh_q[2][0] && im[0]
      |-> ##[3:4] line_irq_out[0]) else $error("fall missed");
  a_rise_irq:
    assert property ($rose(pin_lines_in[0]) && sh_q[3][0] && im[0]
      |-> ##[3:4] line_irq_out[0]) else $error("rise missed");
  a_pending_flag_clear:
    assert property (s_clr |=> (line_irq_out & $past(wlo)) == '0)
      else $error("pending not cleared");
  a_sw_pending_flag:
    assert property (s_swt |=> (line_irq_out & $past(wlo) & im)
      == ($past(wlo) & im)) else $error("soft trigger lost");
  a_ts_route:
    assert property ($rose(sel_ln) && sel_re |-> ##[3:4]
      timestamp_trigger_out) else $error("stamp missed");
  a_ts_single:
    assert property (timestamp_trigger_out |=> !timestamp_trigger_out)
      else $error("stamp too long");
  a_irq_any: assert property (line_irq_out != '0 |-> irq_out)
    else $error("irq output low");
endmodule // line_ctrl_props
bind external_line_controller line_ctrl_props u_props (.clk_sys_in,
  .sys_rst_in, .pin_lines_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .line_irq_out, .event_pulse_out, .timestamp_trigger_out, .irq_out);

// *** verif/line_src_model.sv ***
// Purpose: Far side: line sources and event sink
// Assumes: Bench holds each level for several cycles
// Notes: Levels move only just after a clock edge
// ****
// Source and sink model
// ****
module line_src_model
(
  input wire logic clk_sys_in,
  input wire logic [20:0] want_in,
  input wire logic [20:0] evt_in,
  output logic [20:0] lines_out,
  output logic [31:0] evt_cnt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial lines_out = '0;
  initial evt_cnt_out = '0;
  // Registered so a source never races the sampling edge
  always @(posedge clk_sys_in)
    lines_out <= want_in;
  always @(posedge clk_sys_in)
    evt_cnt_out <= evt_cnt_out + 32'($countones(evt_in));
endmodule // line_src_model

// *** verif/tb_top.sv ***
// Purpose: Self-checking bench for the line controller
// Assumes: Config changes only while source lines are quiet
// Notes: Seeded random masks, edges and soft triggers
`include "line_ctrl_map.svh"
module tb_top
  import line_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 0, sys_rst_in = 1, rw = 0, rr = 0;
  logic ts, irq;
  logic [7:0] ra = '0;
  logic [31:0] wd = '0, ev_exp = '0, ts_cnt = '0;
  logic [31:0] rdv, evc, n0;
  line_vec_t want = '0, pending_flag = '0;
  line_vec_t ln, irqv, evp, c, t;
  line_vec_t cf [0:3] = '{default: '0};
  int failures = 0, check_count = 0;
  external_line_controller dut (.clk_sys_in, .sys_rst_in,
    .pin_lines_in(ln[15:0]), .supply_voltage_detector_in(ln[16]),
    .calendar_alarm_in(ln[17]), .calendar_tamper_stamp_in(ln[18]),
    .calendar_wakeup_in(ln[19]), .basic_timer_wakeup_in(ln[20]),
    .reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(rw), .reg_rd_in(rr),
    .reg_rdata_out(rdv), .line_irq_out(irqv), .event_pulse_out(evp),
    .timestamp_trigger_out(ts), .irq_out(irq));
  line_src_model src (.clk_sys_in, .want_in(want), .evt_in(evp),
    .lines_out(ln), .evt_cnt_out(evc));
  initial
    forever #2 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in)
    if (ts === 1'b1)
      ts_cnt <= ts_cnt + 1;
  // ****
  // Bus tasks and models
  // ****
  task automatic chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    rw <= 1;
    ra <= a;
    wd <= d;
    @(posedge clk_sys_in);
    rw <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_in);
    rr <= 1;
    ra <= a;
    @(posedge clk_sys_in);
    rr <= 0;
    #1 chk(rdv, e);
  endtask
  function automatic line_vec_t trig(line_vec_t o, n);
    return (~o & n & cf[3]) | (o & ~n & cf[2]);
  endfunction
  task automatic cfg(input line_vec_t e, i, f, r);
    pending_flag &= ~((f ^ cf[2]) | (r ^ cf[3]));
    cf = '{e, i, f, r};
    for (int j = 0; j < 4; j++)
      wr(8'(4 * j), 32'(cf[j]));
    for (int j = 0; j < 4; j++)
      rd(8'(4 * j), 32'(cf[j]));
  endtask
  task automatic drive(input line_vec_t n);
    t = trig(want, n);
    pending_flag |= t;
    ev_exp += 32'($countones(t & cf[0]));
    @(posedge clk_sys_in);
    want <= n;
    repeat (5) @(posedge clk_sys_in);
  endtask
  task automatic check_state;
    rd(`LC_OFF_PENDING, 32'(pending_flag));
    chk(32'(irqv), 32'(pending_flag & cf[1]));
    chk(32'(irq), 32'(|(pending_flag & cf[1])));
    chk(evc, ev_exp);
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ****
  // Main sequence
  // ****
  initial
  begin
    void'($urandom(32'hd124));
    repeat (16) @(posedge clk_sys_in);
    sys_rst_in <= 0;
    for (int a = 0; a <= 36; a += 4)
      rd(8'(a), '0);
    check_state();
    for (int k = 0; k < 4; k++)
    begin
      cfg(21'($urandom), 21'($urandom), 21'($urandom), 21'($urandom));
      check_state();
      repeat (8)
        drive(21'($urandom));
      check_state();
      c = 21'($urandom);
      wr(`LC_OFF_PENDING, 32'(c));
      pending_flag &= ~c;
      check_state();
    end
    wr(8'h24, 32'hFFFF_FFFF);
    rd(8'h24, '0);
    wr(`LC_OFF_PENDING, 32'h001F_FFFF);
    pending_flag = '0;
    c = 21'($urandom);
    wr(`LC_OFF_SW_TRIG, 32'(c));
    pending_flag = c;
    ev_exp += 32'($countones(c & cf[0]));
    check_state();
    rd(`LC_OFF_SW_TRIG, 32'(c));
    wr(`LC_OFF_PENDING, 32'(c & 21'h0F_0F0F));
    pending_flag &= ~21'h0F_0F0F;
    rd(`LC_OFF_SW_TRIG, 32'(c & ~21'h0F_0F0F));
    cfg('0, '0, '0, 21'h1F_FFFF);
    drive('0);
    for (int s = 0; s < 16; s++)
    begin
      wr(`LC_OFF_TS_SEL, 32'(s));
      rd(`LC_OFF_TS_SEL, 32'(s));
      n0 = ts_cnt;
      drive(21'(1) << ((s + 1) % 16));
      drive('0);
      drive(21'(1) << s);
      drive('0);
      chk(ts_cnt - n0, 32'h0000_0001);
    end
    check_state();
    // Summary path: sticky status must hold irq after pending goes away
    wr(`LC_OFF_PENDING, 32'h001F_FFFF);
    pending_flag = '0;
    wr(`LC_OFF_SUM_STAT, 32'h0000_0003);
    rd(`LC_OFF_SUM_STAT, '0);
    wr(`LC_OFF_SUM_MASK, 32'h0000_0001);
    wr(`LC_OFF_IRQ_MASK, 32'h0000_0001);
    cf[1] = 21'h00_0001;
    wr(`LC_OFF_SW_TRIG, 32'h0000_0001);
    pending_flag = 21'h00_0001;
    check_state();
    rd(`LC_OFF_SUM_STAT, 32'h0000_0001);
    wr(`LC_OFF_PENDING, 32'h0000_0001);
    pending_flag = '0;
    #1 chk(32'(irq), 32'h0000_0001);
    wr(`LC_OFF_SUM_STAT, 32'h0000_0001);
    #1 chk(32'(irq), 32'h0000_0000);
    check_state();
    summarize();
  end
endmodule // tb_top
